// *** cc_pin_sync.sv ***
// two flip-flop synchroniser for the trunk interface pins
// assumes pins are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module cc_pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_sync
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         // each bit owns its stages so no variable has two writers
         logic meta;
         logic held;
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               meta <= 1'b0;
               held <= 1'b0;
            end else begin
               meta <= pin_async[i];
               held <= meta;
            end
         end
         assign pin_sync[i] = held;
      end
   endgenerate
endmodule : cc_pin_sync
`default_nettype wire

// *** cc_second_tick.sv ***
// divider giving a one-cycle pulse once per second
// assumes clk_sys is free running; cycles is shortened in simulation
`timescale 1ns/1ps
`default_nettype none
module cc_second_tick #(
   parameter int unsigned CYCLES = 100000000
) (
   input wire logic clk_sys,
   input wire logic nrst,
   output logic tick
);
   logic [31:0] count;
   wire logic wrap;

   assign wrap = (count == 32'(CYCLES - 1));

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         count <= 32'h0;
         tick <= 1'b0;
      end else begin
         count <= wrap ? 32'h0 : count + 32'h1;
         tick <= wrap;
      end
   end
endmodule : cc_second_tick
`default_nettype wire

// *** switched_trunk_call_control.sv ***
// call control for a trunk run over a switched data or telephone circuit
// assumes a modem or network terminator behind v.24 pins, a framer on clk_sys
//
// Behaviour
// - idle in data network mode, ring turns on dtr to accept the call
// - after accepting, wait for dsr and cts before synchronising
// - idle in data network mode, trunk data raises dtr, starts 6 s timer
// - outgoing call timer expiring before dsr and cts go high enters retry loop; incoming returns to idle
// - dsr and cts both on during outgoing call starts synchronisation
// - in data phase dsr or cts loss drops dtr; pending data retries
// - data network: after 10 s and idle period, drop dtr, keep circuits
// - after inactivity clear, new trunk data places a new call
// - data network call timeout: drop dtr, back off 1, 5, 9 or 13 s
// - three failed setups: stop, flash sync light, link down, notify
// - while link down every user connection attempt gets out of service
// - link down clears only on incoming call, trunk reset or leaving the data network and modem modes
// - modem mode: trunk data raises dtr so the modem dials
// - modem mode: ring raises dtr so the modem answers, then synchronise
// - modem mode: 90 s from dtr to handshake before call fails
// - modem mode: inactivity timeout 0 to 255 s drops dtr to idle
// - modem mode backoff chosen from 1, 31, 61, 91 or 121 s
// - trunk mode selects mux, data network or telephone call control
`include "switched_trunk_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module switched_trunk_call_control
   import switched_trunk_pkg::*;
#(
   parameter int unsigned SECOND_CYCLES = `CC_SECOND_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [1:0] trunk_mode,
   input wire logic [7:0] inact_secs,
   input wire logic ring_ind,
   input wire logic dsr,
   input wire logic cts,
   input wire logic trunk_clk,
   input wire logic data_pending,
   input wire logic word_xfer,
   input wire logic sync_done,
   input wire logic trunk_reset,
   input wire logic user_conn_req,
   output logic dtr,
   output logic sync_req,
   output logic data_phase,
   output logic sync_led,
   output logic link_down,
   output logic vc_teardown,
   output logic oos_notify,
   output logic [1:0] attempts
);

   logic [`CC_PIN_COUNT-1:0] pins_sync;
   logic sec_tick;
   call_state_e state;
   call_state_e next_state;
   logic [7:0] timer;
   logic [7:0] idle_secs;
   logic [7:0] backoff_secs;
   logic [7:0] lfsr;
   logic orig;
   logic next_orig;
   logic tclk_prev;
   logic clk_seen;

   cc_pin_sync #(
      .WIDTH(`CC_PIN_COUNT)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_async({trunk_clk, cts, dsr, ring_ind}),
      .pin_sync(pins_sync)
   );

   cc_second_tick #(
      .CYCLES(SECOND_CYCLES)
   ) u_second_tick (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .tick(sec_tick)
   );

   wire logic ring_s = pins_sync[`CC_PIN_RING];
   wire logic dsr_s = pins_sync[`CC_PIN_DSR];
   wire logic cts_s = pins_sync[`CC_PIN_CTS];
   wire logic tclk_s = pins_sync[`CC_PIN_TCLK];
   wire logic tclk_rise = tclk_s & ~tclk_prev;

   // only the two switched modes run this machine
   wire logic mode_pdn = (trunk_mode == MODE_PDN);
   wire logic mode_pstn = (trunk_mode == MODE_PSTN);
   wire logic mode_active = mode_pdn | mode_pstn;
   wire logic dce_ready = dsr_s & cts_s;

   // dte takes its clock from the far side: sync waits for a clock edge
   wire logic link_synced = sync_done & clk_seen;

   wire logic [7:0] call_limit =
      mode_pstn ? `CC_PSTN_CALL_S : `CC_PDN_CALL_S;
   wire logic call_expired = (timer >= call_limit);

   // modem mode uses the timeout itself as the minimum call duration
   wire logic [7:0] min_call =
      mode_pstn ? inact_secs : `CC_PDN_MIN_CALL_S;
   wire logic inactive =
      (timer >= min_call) & (idle_secs >= inact_secs);

   wire logic last_try = (attempts == (`CC_MAX_ATTEMPTS - 2'h1));
   wire logic fail_state = (state == ST_CALL) | (state == ST_SYNC);
   wire logic setup_fail = fail_state & call_expired &
      !(state == ST_CALL && dce_ready) &
      !(state == ST_SYNC && link_synced);
   wire logic orig_fail = setup_fail & orig;

   // backoff choice: four slots in data network, five in modem mode
   wire logic [2:0] pstn_slot = (lfsr[2:0] >= `CC_PSTN_BACKOFF_CHOICES) ?
      lfsr[2:0] - `CC_PSTN_BACKOFF_CHOICES : lfsr[2:0];
   wire logic [7:0] pdn_pick = `CC_PDN_BACKOFF_BASE_S +
      8'(`CC_PDN_BACKOFF_STEP_S * {6'h0, lfsr[1:0]});
   wire logic [7:0] pstn_pick = `CC_PSTN_BACKOFF_BASE_S +
      8'(`CC_PSTN_BACKOFF_STEP_S * {5'h0, pstn_slot});
   wire logic [7:0] backoff_pick = mode_pstn ? pstn_pick : pdn_pick;

   wire logic state_chg = (next_state != state) &&
      !(state == ST_CALL && next_state == ST_SYNC);
   wire logic enter_down = (next_state == ST_DOWN) && (state != ST_DOWN);
   wire logic next_dtr = (next_state == ST_CALL) ||
      (next_state == ST_SYNC) || (next_state == ST_DATA);

   always_comb begin
      next_state = state;
      next_orig = orig;
      if (trunk_reset || !mode_active) begin
         next_state = ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (ring_s) begin
                  next_state = ST_CALL;
                  next_orig = 1'b0;
               end else if (data_pending) begin
                  next_state = ST_CALL;
                  next_orig = 1'b1;
               end
            end
            ST_CALL: begin
               if (dce_ready) begin
                  next_state = ST_SYNC;
               end else if (call_expired) begin
                  next_state = !orig ? ST_IDLE :
                     last_try ? ST_DOWN : ST_BACKOFF;
               end
            end
            ST_SYNC: begin
               if (link_synced) begin
                  next_state = ST_DATA;
               end else if (call_expired) begin
                  next_state = !orig ? ST_IDLE :
                     last_try ? ST_DOWN : ST_BACKOFF;
               end
            end
            ST_DATA: begin
               if (!dce_ready) begin
                  next_state = data_pending ? ST_BACKOFF : ST_IDLE;
                  next_orig = 1'b1;
               end else if (inactive) begin
                  next_state = ST_IDLE;
               end
            end
            ST_BACKOFF: begin
               if (timer >= backoff_secs) begin
                  next_state = ST_CALL;
               end
            end
            ST_DOWN: begin
               if (ring_s) begin
                  next_state = ST_CALL;
                  next_orig = 1'b0;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         orig <= 1'b0;
      end else begin
         state <= next_state;
         orig <= next_orig;
      end
   end

   // whole-second timer; call and sync share one count so the limit spans both
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         timer <= 8'h0;
      end else if (state_chg) begin
         timer <= 8'h0;
      end else if (sec_tick && timer != `CC_TIMER_MAX) begin
         timer <= timer + 8'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         idle_secs <= 8'h0;
      end else if (word_xfer || state_chg) begin
         idle_secs <= 8'h0;
      end else if (sec_tick && idle_secs != `CC_TIMER_MAX) begin
         idle_secs <= idle_secs + 8'h1;
      end
   end

   // free running lfsr; both ends differ in start time, not seed
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lfsr <= `CC_LFSR_SEED;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         backoff_secs <= 8'h0;
      end else if (next_state == ST_BACKOFF && state != ST_BACKOFF) begin
         backoff_secs <= backoff_pick;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         attempts <= 2'h0;
      end else if (next_state == ST_DATA || trunk_reset ||
                   (state == ST_DOWN && next_state != ST_DOWN)) begin
         attempts <= 2'h0;
      end else if (orig_fail && attempts != `CC_MAX_ATTEMPTS) begin
         attempts <= attempts + 2'h1;
      end
   end

   // a clock edge must be seen after dce ready before data starts
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tclk_prev <= 1'b0;
         clk_seen <= 1'b0;
      end else begin
         tclk_prev <= tclk_s;
         if (state != ST_SYNC) begin
            clk_seen <= 1'b0;
         end else if (tclk_rise) begin
            clk_seen <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dtr <= 1'b0;
         sync_req <= 1'b0;
         data_phase <= 1'b0;
         link_down <= 1'b0;
         vc_teardown <= 1'b0;
         oos_notify <= 1'b0;
      end else begin
         dtr <= next_dtr;
         sync_req <= (next_state == ST_SYNC);
         data_phase <= (next_state == ST_DATA);
         link_down <= (next_state == ST_DOWN);
         vc_teardown <= enter_down;
         oos_notify <= enter_down ||
            (state == ST_DOWN && user_conn_req);
      end
   end

   // light steady in data phase, flashing at 1 s while down
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync_led <= 1'b0;
      end else if (next_state == ST_DOWN) begin
         sync_led <= sec_tick ? ~sync_led : sync_led;
      end else begin
         sync_led <= (next_state == ST_DATA);
      end
   end

   AST_RING_ACCEPT: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_IDLE && mode_active && ring_s && !trunk_reset
      |=> dtr && state == ST_CALL && !orig)
      else $error("ring in idle did not raise dtr");

   AST_WAIT_READY: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_CALL && !dce_ready |=> state != ST_SYNC)
      else $error("synchronising without dsr and cts");

   AST_OUT_CALL: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_IDLE && mode_active && !ring_s && data_pending &&
      !trunk_reset |=> dtr && orig && timer == 8'h0)
      else $error("trunk data in idle did not start a call");

   AST_CALL_LIMIT: assert property (@(posedge clk_sys) disable iff (!nrst)
      fail_state && mode_pdn && timer < 8'h06 && !trunk_reset
      |=> dtr)
      else $error("data network call dropped before 6 s");

   AST_PSTN_LIMIT: assert property (@(posedge clk_sys) disable iff (!nrst)
      fail_state && mode_pstn && timer < 8'h5a && !trunk_reset
      |=> dtr)
      else $error("modem call dropped before 90 s");

   AST_CALL_SPAN: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_CALL && dce_ready && mode_active && !trunk_reset
      && !sec_tick |=> state == ST_SYNC && timer == $past(timer))
      else $error("handshake restarted the call timer");

   AST_RETRY: assert property (@(posedge clk_sys) disable iff (!nrst)
      orig_fail && !last_try && mode_active && !trunk_reset
      |=> state == ST_BACKOFF && !dtr ##1 !dtr)
      else $error("call timeout did not enter backoff");

   AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_DATA && !dce_ready |=> !dtr && !data_phase)
      else $error("dsr or cts loss did not drop dtr");

   AST_INACTIVE: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_DATA && dce_ready && mode_pdn && timer < 8'h0a
      && !trunk_reset |=> dtr)
      else $error("call cleared before minimum duration");

   AST_BACKOFF_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_BACKOFF && mode_pdn |-> backoff_secs inside
      {8'h01, 8'h05, 8'h09, 8'h0d})
      else $error("data network backoff outside the allowed set");

   AST_PSTN_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_BACKOFF && mode_pstn |-> backoff_secs inside
      {8'h01, 8'h1f, 8'h3d, 8'h5b, 8'h79})
      else $error("modem backoff outside the allowed set");

   AST_DOWN: assert property (@(posedge clk_sys) disable iff (!nrst)
      orig_fail && last_try && mode_active && !trunk_reset
      |=> link_down && vc_teardown && oos_notify ##1 !vc_teardown
      )
      else $error("third failure did not take the link down");

   AST_OOS: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_DOWN && user_conn_req |=> oos_notify)
      else $error("user attempt while down not refused");

   AST_DOWN_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_DOWN && !ring_s && !trunk_reset && mode_active
      |=> link_down)
      else $error("link down cleared without cause");

   AST_COUNT: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == ST_DATA |-> attempts == 2'h0)
      else $error("attempt counter not cleared on link up");

endmodule : switched_trunk_call_control
`default_nettype wire

// *** switched_trunk_call_control_test.sv ***
// self-checking bench for the switched trunk call control
// assumes a 500 ns second (SECOND_CYCLES 50) to keep timers short
`timescale 1ns/1ps
`default_nettype none
module switched_trunk_call_control_test;
   import switched_trunk_pkg::*;
   localparam int SEC = 50;
   typedef struct {logic [1:0] mode; logic call; logic slow;} row_s;
   row_s rows [4] = '{'{2'h1, 1'b1, 1'b0}, '{2'h2, 1'b1, 1'b1},
                      '{2'h0, 1'b0, 1'b0}, '{2'h3, 1'b0, 1'b0}};
   logic clk_sys = 1'b0, nrst = 1'b0;
   logic [1:0] trunk_mode = 2'h1;
   logic [7:0] inact_secs = 8'h02;
   logic ring_ind, dsr, cts, trunk_clk, dtr, sync_req, data_phase;
   logic data_pending = 1'b0, word_xfer = 1'b0, sync_done = 1'b1;
   logic trunk_reset = 1'b0, user_conn_req = 1'b0, ring_cmd = 1'b0;
   logic answer_en = 1'b1, answer_slow = 1'b0, s;
   logic sync_led, link_down, vc_teardown, oos_notify;
   logic [1:0] attempts;
   int n_mismatch = 0, num_checks = 0, n, n_tear = 0, n_oos = 0;
   always #5 clk_sys = ~clk_sys;
   trunk_dce_model trunk_dce_model_inst (.dtr(dtr), .answer_en(answer_en),
      .answer_slow(answer_slow), .ring_cmd(ring_cmd), .ring_ind(ring_ind),
      .dsr(dsr), .cts(cts), .trunk_clk(trunk_clk));
   switched_trunk_call_control #(.SECOND_CYCLES(SEC))
      switched_trunk_call_control_inst (.clk_sys(clk_sys), .nrst(nrst),
      .trunk_mode(trunk_mode), .inact_secs(inact_secs), .ring_ind(ring_ind),
      .dsr(dsr), .cts(cts), .trunk_clk(trunk_clk),
      .data_pending(data_pending), .word_xfer(word_xfer),
      .sync_done(sync_done), .trunk_reset(trunk_reset),
      .user_conn_req(user_conn_req), .dtr(dtr), .sync_req(sync_req),
      .data_phase(data_phase), .sync_led(sync_led), .link_down(link_down),
      .vc_teardown(vc_teardown), .oos_notify(oos_notify),
      .attempts(attempts));
   // pulses are counted so a doubled or missing pulse shows up later
   always @(posedge clk_sys) begin
      if (vc_teardown === 1'b1) n_tear++;
      if (oos_notify === 1'b1) n_oos++;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic pick(input int w);
      case (w)
         0: return dtr;
         1: return data_phase;
         default: return sync_req;
      endcase
   endfunction : pick
   // bounded wait for an output level; running out ends the run
   task automatic wait_for(input int w, input logic lvl, input int lim,
         output int k);
      k = 0;
      while (pick(w) !== lvl) begin
         step(1);
         k++;
         if (k > lim) begin
            chk(pick(w), lvl);
            finish_test();
         end
      end
   endtask : wait_for
   task automatic do_reset();
      nrst = 1'b0;
      step(12);
      chk({dtr, sync_req, data_phase, sync_led, link_down, attempts}, 0);
      nrst = 1'b1;
      step(2);
   endtask : do_reset
   // three unanswered calls in the given mode end in link down
   task automatic go_down(input logic [1:0] md);
      int lim;
      int bk;
      lim = (md == 2'h2) ? 90 : 6;
      bk = (md == 2'h2) ? 121 : 13;
      answer_en = 1'b0;
      trunk_mode = md;
      data_pending = 1'b1;
      n_tear = 0;
      n_oos = 0;
      for (int k = 1; k <= 3; k++) begin
         wait_for(0, 1'b1, (k == 1) ? 10 : bk * SEC + 60, n);
         wait_for(0, 1'b0, lim * SEC + 20, n);
         chk(n >= (lim - 1) * SEC - 10, 1'b1);
         step(3);
         if (k < 3) chk(attempts, k);
      end
      chk(link_down, 1'b1);
      chk(n_tear, 1);
      s = sync_led;
      step(SEC);
      chk(sync_led, !s);
      step(16 * SEC);
      chk(dtr, 1'b0);
   endtask : go_down
   initial begin
      do_reset();
      foreach (rows[i]) begin
         trunk_mode = rows[i].mode;
         answer_slow = rows[i].slow;
         step(2);
         data_pending = 1'b1;
         step(6);
         chk(dtr, rows[i].call);
         if (rows[i].call) begin
            wait_for(1, 1'b1, 91 * SEC, n);
            chk(sync_led, 1'b1);
            answer_en = 1'b0;
            data_pending = 1'b0;
            wait_for(0, 1'b0, 40, n);
            chk({data_phase, attempts}, 0);
         end
         data_pending = 1'b0;
         answer_en = 1'b1;
         answer_slow = 1'b0;
         step(10);
      end
      // incoming call held in sync until the framer reports
      trunk_mode = 2'h1;
      sync_done = 1'b0;
      ring_cmd = 1'b1;
      step(5);
      chk(dtr, 1'b1);
      step(40);
      chk({sync_req, data_phase}, 2'h2);
      sync_done = 1'b1;
      ring_cmd = 1'b0;
      wait_for(1, 1'b1, 20, n);
      wait_for(0, 1'b0, 14 * SEC, n);
      chk(n >= 9 * SEC - 10, 1'b1);
      data_pending = 1'b1;
      step(6);
      chk(dtr, 1'b1);
      wait_for(1, 1'b1, 40, n);
      // modem mode: word traffic keeps the line, silence drops it
      trunk_mode = 2'h2;
      data_pending = 1'b0;
      inact_secs = 8'h03;
      for (int k = 0; k < 10; k++) begin
         word_xfer = 1'b1;
         step(1);
         word_xfer = 1'b0;
         step(SEC);
      end
      chk(dtr, 1'b1);
      wait_for(0, 1'b0, 4 * SEC + 10, n);
      chk(n >= SEC - 10 && n <= 2 * SEC + 10, 1'b1);
      // ring in modem mode answers, then a loss of line ends data
      ring_cmd = 1'b1;
      step(5);
      chk(dtr, 1'b1);
      ring_cmd = 1'b0;
      wait_for(1, 1'b1, 40, n);
      answer_en = 1'b0;
      wait_for(0, 1'b0, 40, n);
      // link down, user refusals, then clearing it by trunk reset and by ring
      for (int c = 0; c < 2; c++) begin
         go_down((c == 0) ? 2'h1 : 2'h2);
         user_conn_req = 1'b1;
         step(2);
         user_conn_req = 1'b0;
         step(2);
         chk(n_oos, 3);
         data_pending = 1'b0;
         if (c == 0) begin
            trunk_reset = 1'b1;
            step(1);
            trunk_reset = 1'b0;
         end else begin
            answer_en = 1'b1;
            ring_cmd = 1'b1;
         end
         step(6);
         chk({link_down, attempts}, 0);
         if (c == 1) wait_for(1, 1'b1, 40, n);
         ring_cmd = 1'b0;
      end
      do_reset();
      finish_test();
   end
endmodule : switched_trunk_call_control_test
`default_nettype wire

// *** switched_trunk_defines.svh ***
// timing and selection constants for the switched trunk call control
// assumes a 100 MHz system clock and timers counted in whole seconds
`ifndef SWITCHED_TRUNK_DEFINES_SVH
`define SWITCHED_TRUNK_DEFINES_SVH

`define CC_CLK_PERIOD_NS 10
`define CC_SECOND_NS 1000000000
`define CC_SECOND_CYCLES (`CC_SECOND_NS / `CC_CLK_PERIOD_NS)

`define CC_PDN_CALL_S 8'h06
`define CC_PSTN_CALL_S 8'h5a
`define CC_PDN_MIN_CALL_S 8'h0a
`define CC_PDN_BACKOFF_BASE_S 8'h01
`define CC_PDN_BACKOFF_STEP_S 8'h04
`define CC_PSTN_BACKOFF_BASE_S 8'h01
`define CC_PSTN_BACKOFF_STEP_S 8'h1e
`define CC_PSTN_BACKOFF_CHOICES 3'h5
`define CC_MAX_ATTEMPTS 2'h3
`define CC_TIMER_MAX 8'hff
`define CC_LFSR_SEED 8'h5b

`define CC_PIN_RING 0
`define CC_PIN_DSR 1
`define CC_PIN_CTS 2
`define CC_PIN_TCLK 3
`define CC_PIN_COUNT 4

`endif

// *** switched_trunk_pkg.sv ***
// types shared by the switched trunk call control files
// assumes the constants header is compiled alongside
`default_nettype none
package switched_trunk_pkg;

   typedef enum logic [1:0] {
      MODE_MUX = 2'h0,
      MODE_PDN = 2'h1,
      MODE_PSTN = 2'h2
   } trunk_mode_e;

   // gray codes along idle, call, sync, data
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CALL = 3'h1,
      ST_SYNC = 3'h3,
      ST_DATA = 3'h2,
      ST_BACKOFF = 3'h6,
      ST_DOWN = 3'h4
   } call_state_e;

endpackage : switched_trunk_pkg
`default_nettype wire

// *** trunk_dce_model.sv ***
// far-side network terminator or modem model on the v.24 trunk pins
// assumes dtr comes from the device and commands come from the testbench
`timescale 1ns/1ps
`default_nettype none
module trunk_dce_model (
   input wire logic dtr,
   input wire logic answer_en,
   input wire logic answer_slow,
   input wire logic ring_cmd,
   output logic ring_ind,
   output logic dsr,
   output logic cts,
   output logic trunk_clk
);
   int up_ns = 0;
   initial begin
      dsr = 1'b0;
      cts = 1'b0;
      trunk_clk = 1'b0;
   end
   assign ring_ind = ring_cmd;
   // line rises only while dtr is held; slow answer is 80 s at 500 ns a second
   always begin
      #25;
      up_ns = (dtr === 1'b1 && answer_en) ? up_ns + 25 : 0;
      dsr = up_ns >= (answer_slow ? 40000 : 200);
      cts = dsr;
   end
   // clock comes from the far side and stands still outside a call
   always begin
      #62.5;
      if (dsr) begin
         trunk_clk = ~trunk_clk;
      end
   end
endmodule : trunk_dce_model
`default_nettype wire
